// File: cwbd_pkg.sv
// Shared constants and types for the complementary bridge waveform unit
package cwbd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DB_W = 6;
    localparam int SRC_SEL_W = 4;
    localparam int N_OUT = 4;

    // ------------------------------------------------------------
    // Clock rates for the block clock enable
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 40;
    localparam int FAST_OSC_MHZ = 16;
    localparam int ACC_W = 7;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(FAST_OSC_MHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(SYS_CLK_MHZ);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DB_W-1:0] DB_RST = 6'h00;
    localparam logic [N_OUT-1:0] OUT_RST = 4'h0;
    localparam logic [ACC_W-1:0] ACC_RST = 7'h00;

    // ------------------------------------------------------------
    // Clock select values
    // ------------------------------------------------------------
    localparam logic CLK_SEL_SYS = 1'b0;
    localparam logic CLK_SEL_FAST = 1'b1;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CWBD_STEER_ASYNC = 3'b000,
        CWBD_STEER_SYNC = 3'b001,
        CWBD_FULL_FWD = 3'b010,
        CWBD_FULL_REV = 3'b011,
        CWBD_HALF = 3'b100,
        CWBD_PUSH_PULL = 3'b101,
        CWBD_RSVD_6 = 3'b110,
        CWBD_RSVD_7 = 3'b111
    } cwbd_mode_t;

    // Static configuration from software; pol bit set means active-high
    typedef struct packed {
        cwbd_mode_t mode;
        logic [N_OUT-1:0] pol;
        logic [N_OUT-1:0] steer;
        logic clk_sel;
        logic [SRC_SEL_W-1:0] in_sel;
    } cwbd_cfg_t;

    // Dead-band write strobes and data
    typedef struct packed {
        logic rise_wr;
        logic [DB_W-1:0] rise_val;
        logic fall_wr;
        logic [DB_W-1:0] fall_val;
        logic load_req;
    } cwbd_db_wr_t;

endpackage

// File: cwbd_bridge_driver.sv
// Complementary bridge waveform unit: mode logic, dead band, polarity, steering
module cwbd_bridge_driver #(
    parameter int N_SRC = 16
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic EN_IN,
    input wire logic SHUTDOWN_IN,
    input wire cwbd_pkg::cwbd_cfg_t CFG_IN,
    input wire cwbd_pkg::cwbd_db_wr_t DB_WR_IN,
    input wire logic [N_SRC-1:0] SRC_IN,
    output logic BRIDGE_OUT_A_OUT,
    output logic BRIDGE_OUT_B_OUT,
    output logic BRIDGE_OUT_C_OUT,
    output logic BRIDGE_OUT_D_OUT,
    output logic LOAD_PENDING_OUT,
    output logic [cwbd_pkg::DB_W-1:0] RISE_DB_ACTIVE_OUT,
    output logic [cwbd_pkg::DB_W-1:0] FALL_DB_ACTIVE_OUT,
    output logic PP_PHASE_OUT,
    output logic DIR_REVERSE_OUT
);
    import cwbd_pkg::*;

    // ------------------------------------------------------------
    // Input source synchroniser and selection
    // ------------------------------------------------------------
    logic [N_SRC-1:0] src_meta_ff;
    logic [N_SRC-1:0] src_sync_ff;
    logic sig_d_ff;
    logic sig;
    logic sig_rise;
    logic sig_fall;
    logic en;
    cwbd_mode_t mode;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            src_meta_ff <= '0;
            src_sync_ff <= '0;
        end
        else
        begin
            src_meta_ff <= SRC_IN;
            src_sync_ff <= src_meta_ff;
        end
    end

    // Out-of-range selections read as a quiet low input
    assign sig = (32'(CFG_IN.in_sel) < N_SRC) ? src_sync_ff[CFG_IN.in_sel] : 1'b0;
    assign sig_rise = sig & ~sig_d_ff;
    assign sig_fall = ~sig & sig_d_ff;
    assign en = EN_IN;
    assign mode = CFG_IN.mode;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
            sig_d_ff <= 1'b0;
        else
            sig_d_ff <= sig;
    end

    // ------------------------------------------------------------
    // Block clock enable
    // ------------------------------------------------------------
    // The fast oscillator rate is made as a fractional enable from the one core clock
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] acc_sum;
    logic tick;

    assign acc_sum = acc_ff + ACC_STEP;
    assign tick = (CFG_IN.clk_sel == CLK_SEL_SYS) ? 1'b1 : (acc_sum >= ACC_WRAP);

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN || CFG_IN.clk_sel == CLK_SEL_SYS)
            acc_ff <= ACC_RST;
        else if (acc_sum >= ACC_WRAP)
            acc_ff <= acc_sum - ACC_WRAP;
        else
            acc_ff <= acc_sum;
    end

    // ------------------------------------------------------------
    // Dead-band double buffer
    // ------------------------------------------------------------
    logic [DB_W-1:0] dbr_buf_ff;
    logic [DB_W-1:0] dbf_buf_ff;
    logic [DB_W-1:0] dbr_act_ff;
    logic [DB_W-1:0] dbf_act_ff;
    logic ld_ff;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            dbr_buf_ff <= DB_RST;
            dbr_act_ff <= DB_RST;
        end
        else if (DB_WR_IN.rise_wr)
        begin
            dbr_buf_ff <= DB_WR_IN.rise_val;
            if (!en)
                dbr_act_ff <= DB_WR_IN.rise_val;
        end
        else if (en && ld_ff && sig_fall)
            dbr_act_ff <= dbr_buf_ff;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            dbf_buf_ff <= DB_RST;
            dbf_act_ff <= DB_RST;
        end
        else if (DB_WR_IN.fall_wr)
        begin
            dbf_buf_ff <= DB_WR_IN.fall_val;
            if (!en)
                dbf_act_ff <= DB_WR_IN.fall_val;
        end
        else if (en && ld_ff && sig_fall)
            dbf_act_ff <= dbf_buf_ff;
    end

    // A new request in the load cycle keeps the flag set
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
            ld_ff <= 1'b0;
        else if (DB_WR_IN.load_req)
            ld_ff <= 1'b1;
        else if (en && sig_fall)
            ld_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Full-bridge direction
    // ------------------------------------------------------------
    logic is_full;
    logic is_half;
    logic dir_rev_ff;
    logic fb_wait_ff;
    logic dir_change;
    logic [1:0] db_done_ff;

    assign is_full = (mode == CWBD_FULL_FWD) || (mode == CWBD_FULL_REV);
    assign is_half = (mode == CWBD_HALF);
    assign dir_change = is_full && sig_rise && (mode[0] != dir_rev_ff);

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            dir_rev_ff <= 1'b0;
            fb_wait_ff <= 1'b0;
        end
        else if (!en || !is_full)
        begin
            dir_rev_ff <= mode[0];
            fb_wait_ff <= 1'b0;
        end
        else if (dir_change)
        begin
            dir_rev_ff <= mode[0];
            fb_wait_ff <= 1'b1;
        end
        else if (fb_wait_ff && db_done_ff[dir_rev_ff ? 0 : 1])
            fb_wait_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Dead-band counters: index 0 rise/reverse, index 1 fall/forward
    // ------------------------------------------------------------
    logic [DB_W-1:0] db_cnt_ff [2];
    logic [1:0] db_run_ff;
    logic [1:0] db_start;
    logic [1:0] db_abort;
    logic [DB_W-1:0] db_lim [2];

    assign db_lim[0] = dbr_act_ff;
    assign db_lim[1] = dbf_act_ff;
    assign db_start[0] = is_half ? sig_rise : (dir_change && mode[0]);
    assign db_start[1] = is_half ? sig_fall : (dir_change && !mode[0]);
    // In half-bridge mode only, losing the input mid-count cancels the pending edge
    assign db_abort[0] = is_half && sig_fall;
    assign db_abort[1] = is_half && sig_rise;

    always_ff @(posedge CORE_CLK_IN)
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (!RST_N_IN || !en || !(is_half || is_full))
            begin
                db_cnt_ff[k] <= DB_RST;
                db_run_ff[k] <= 1'b0;
                db_done_ff[k] <= 1'b0;
            end
            else if (db_start[k])
            begin
                db_cnt_ff[k] <= DB_RST;
                db_run_ff[k] <= (db_lim[k] != DB_RST);
                db_done_ff[k] <= (db_lim[k] == DB_RST);
            end
            else if (db_abort[k])
            begin
                db_cnt_ff[k] <= DB_RST;
                db_run_ff[k] <= 1'b0;
                db_done_ff[k] <= 1'b0;
            end
            else if (db_run_ff[k] && tick)
            begin
                db_cnt_ff[k] <= db_cnt_ff[k] + 6'h01;
                if (db_cnt_ff[k] + 6'h01 == db_lim[k])
                begin
                    db_run_ff[k] <= 1'b0;
                    db_done_ff[k] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Push-pull sequencer
    // ------------------------------------------------------------
    logic pp_phase_ff;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN || !en || SHUTDOWN_IN)
            pp_phase_ff <= 1'b0;
        else if (mode == CWBD_PUSH_PULL && sig_fall)
            pp_phase_ff <= ~pp_phase_ff;
    end

    // ------------------------------------------------------------
    // Steering selection
    // ------------------------------------------------------------
    logic [N_OUT-1:0] steer_act_ff;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
            steer_act_ff <= OUT_RST;
        else if (mode == CWBD_STEER_ASYNC)
            steer_act_ff <= CFG_IN.steer;
        else if (mode != CWBD_STEER_SYNC || sig_rise)
            steer_act_ff <= CFG_IN.steer;
    end

    // ------------------------------------------------------------
    // Output formation
    // ------------------------------------------------------------
    logic [N_OUT-1:0] raw;
    logic [N_OUT-1:0] out_nxt;
    logic [N_OUT-1:0] out_ff;

    always_comb
    begin
        raw = OUT_RST;
        case (mode)
            CWBD_HALF:
            begin
                raw[0] = sig & db_done_ff[0];
                raw[1] = ~sig & db_done_ff[1];
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            CWBD_PUSH_PULL:
            begin
                raw[0] = sig & ~pp_phase_ff;
                raw[1] = sig & pp_phase_ff;
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            CWBD_FULL_FWD, CWBD_FULL_REV:
            begin
                raw[0] = ~dir_rev_ff;
                raw[2] = dir_rev_ff;
                raw[1] = dir_rev_ff & sig & ~fb_wait_ff;
                raw[3] = ~dir_rev_ff & sig & ~fb_wait_ff;
            end
            CWBD_STEER_ASYNC, CWBD_STEER_SYNC:
                raw = steer_act_ff & {N_OUT{sig}};
            default:
                raw = OUT_RST;
        endcase
    end

    always_comb
    begin
        out_nxt = ~CFG_IN.pol;
        if (en)
        begin
            for (int k = 0; k < N_OUT; k++)
            begin
                if ((mode == CWBD_STEER_ASYNC || mode == CWBD_STEER_SYNC) && !steer_act_ff[k])
                    out_nxt[k] = 1'b0;
                else
                    out_nxt[k] = CFG_IN.pol[k] ? raw[k] : ~raw[k];
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
            out_ff <= OUT_RST;
        else
            out_ff <= out_nxt;
    end

    assign BRIDGE_OUT_A_OUT = out_ff[0];
    assign BRIDGE_OUT_B_OUT = out_ff[1];
    assign BRIDGE_OUT_C_OUT = out_ff[2];
    assign BRIDGE_OUT_D_OUT = out_ff[3];
    assign LOAD_PENDING_OUT = ld_ff;
    assign RISE_DB_ACTIVE_OUT = dbr_act_ff;
    assign FALL_DB_ACTIVE_OUT = dbf_act_ff;
    assign PP_PHASE_OUT = pp_phase_ff;
    assign DIR_REVERSE_OUT = dir_rev_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    a_disabled_idle: assert property (!en |=> out_ff == ~$past(CFG_IN.pol))
        else $error("disabled outputs not inactive");
    a_pp_reset: assert property ((!en || SHUTDOWN_IN) |=> !pp_phase_ff)
        else $error("push-pull sequencer not reset");
    a_pp_advance: assert property (en && !SHUTDOWN_IN && mode == CWBD_PUSH_PULL && sig_fall
        |=> pp_phase_ff != $past(pp_phase_ff))
        else $error("push-pull sequencer did not advance");
    a_db_direct: assert property (!en && DB_WR_IN.rise_wr
        |=> dbr_act_ff == $past(DB_WR_IN.rise_val))
        else $error("disabled write did not load active value");
    a_db_load: assert property (en && ld_ff && sig_fall && !DB_WR_IN.fall_wr && !DB_WR_IN.load_req
        |=> dbf_act_ff == $past(dbf_buf_ff) && !ld_ff)
        else $error("load request not served at falling edge");
    a_half_gap: assert property (en && is_half && sig_rise && dbr_act_ff == 6'h02
        && CFG_IN.clk_sel == CLK_SEL_SYS ##1 (is_half && sig && en)[*2]
        |-> !db_done_ff[0] ##1 db_done_ff[0])
        else $error("rising dead band length wrong");
    a_fb_static: assert property (en && is_full && !dir_rev_ff
        |=> out_ff[0] == $past(CFG_IN.pol[0]) && out_ff[2] == !$past(CFG_IN.pol[2]))
        else $error("forward static levels wrong");
    a_sync_steer: assert property (en && mode == CWBD_STEER_SYNC && !sig_rise
        |=> $stable(steer_act_ff))
        else $error("sync steering changed without rising edge");
    a_async_steer: assert property (mode == CWBD_STEER_ASYNC
        |=> steer_act_ff == $past(CFG_IN.steer))
        else $error("async steering not applied next cycle");
    a_fast_tick: assert property (CFG_IN.clk_sel == CLK_SEL_FAST && tick
        ##1 CFG_IN.clk_sel == CLK_SEL_FAST |-> !tick)
        else $error("fast oscillator enable too frequent");

    c_pp_two: cover property (en && mode == CWBD_PUSH_PULL && out_ff[0] != out_ff[1]
        && pp_phase_ff);
    c_dir_flip: cover property (en && dir_change ##[1:100] !fb_wait_ff);
    c_ld_load: cover property (en && ld_ff && sig_fall);
    c_half_both: cover property (en && is_half && db_done_ff[0] ##[1:200] db_done_ff[1]);

endmodule

// File: cwbd_gate_model.sv
// Behavioural model of the gate drivers on the bridge legs
module cwbd_gate_model
    import cwbd_pkg::*;
(
    input wire logic clk_in,
    input wire logic half_mode_in,
    input wire logic [N_OUT-1:0] pol_in,
    input wire logic [N_OUT-1:0] legs_in,
    output int overlap_count_out
);
    // ------------------------------------------------------------
    // Shoot-through watch
    // ------------------------------------------------------------
    // Both switches of one leg on together would short the supply
    initial overlap_count_out = 0;
    always @(posedge clk_in)
    begin
        if (half_mode_in && legs_in[0] === pol_in[0] && legs_in[1] === pol_in[1])
        begin
            overlap_count_out <= overlap_count_out + 1;
        end
    end
endmodule

// File: tb.sv
// Self-checking testbench for the bridge waveform unit
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cwbd_pkg::*;
    logic clk, rst_n, en, sd, oa, ob, oc, od, pend, phase, dir;
    cwbd_cfg_t cfg;
    cwbd_db_wr_t dbw;
    logic [15:0] src;
    logic [DB_W-1:0] rise_act, fall_act;
    logic [3:0] outs;
    int miscompares, num_checks, overlaps, n, m;
    assign outs = {od, oc, ob, oa};

    cwbd_bridge_driver #(.N_SRC(16)) uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .EN_IN(en),
        .SHUTDOWN_IN(sd), .CFG_IN(cfg), .DB_WR_IN(dbw), .SRC_IN(src),
        .BRIDGE_OUT_A_OUT(oa), .BRIDGE_OUT_B_OUT(ob), .BRIDGE_OUT_C_OUT(oc),
        .BRIDGE_OUT_D_OUT(od), .LOAD_PENDING_OUT(pend), .RISE_DB_ACTIVE_OUT(rise_act),
        .FALL_DB_ACTIVE_OUT(fall_act), .PP_PHASE_OUT(phase), .DIR_REVERSE_OUT(dir));
    cwbd_gate_model gates (.clk_in(clk), .half_mode_in(en && cfg.mode == CWBD_HALF),
        .pol_in(cfg.pol), .legs_in(outs), .overlap_count_out(overlaps));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic drive_in(input logic v);
        @(posedge clk);
        src[cfg.in_sel] <= v;
        #1;
    endtask
    // Edges from the last input change until the chosen output shows val
    task automatic edges_until(input int idx, input logic v, output int k);
        k = 0;
        while (outs[idx] !== v && k < 200)
        begin
            step(1);
            k++;
        end
    endtask
    task automatic setup(input cwbd_mode_t md, input logic [3:0] pl, input logic [3:0] st,
                         input logic cs);
        @(posedge clk);
        en <= 1'h0;
        src <= 16'h0000;
        cfg <= '{md, pl, st, cs, 4'h5};
        step(2);
    endtask
    task automatic write_db(input logic [5:0] r, input logic [5:0] f, input logic ld);
        @(posedge clk);
        dbw <= '{1'h1, r, 1'h1, f, ld};
        @(posedge clk);
        dbw <= '0;
        #1;
    endtask
    task automatic start;
        @(posedge clk);
        en <= 1'h1;
        step(4);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_half;
        setup(CWBD_HALF, 4'h7, 4'h0, CLK_SEL_SYS);
        check(outs, 4'h8, "idle levels");
        write_db(6'h02, 6'h03, 1'h0);
        check(rise_act, 6'h02, "rise direct");
        check(fall_act, 6'h03, "fall direct");
        start;
        drive_in(1'h1);
        edges_until(0, 1'h1, n);
        check(n, 6, "A lead delay");
        check({oc, ob, od}, 3'h5, "C D mirror");
        drive_in(1'h0);
        edges_until(1, 1'h1, n);
        check(n, 7, "B lead delay");
        check({oa, oc, od}, 3'h0, "after fall");
        check(overlaps, 0, "no overlap");
        $display("test half done");
    endtask
    task automatic test_short_and_load;
        setup(CWBD_HALF, 4'hF, 4'h0, CLK_SEL_SYS);
        write_db(6'h05, 6'h03, 1'h0);
        start;
        drive_in(1'h1);
        step(2);
        drive_in(1'h0);
        m = 0;
        repeat (12)
        begin
            step(1);
            m = m | oa;
        end
        check(m, 0, "short pulse swallowed");
        write_db(6'h01, 6'h04, 1'h1);
        check(rise_act, 6'h05, "buffered rise");
        check(pend, 1'h1, "load pending");
        drive_in(1'h1);
        step(9);
        drive_in(1'h0);
        step(6);
        check({pend, rise_act, fall_act}, {1'h0, 6'h01, 6'h04}, "load at fall");
        $display("test short and load done");
    endtask
    task automatic pp_pulse(input logic exp_a);
        drive_in(1'h1);
        step(8);
        check({oa, ob}, {exp_a, ~exp_a}, "pulse leg");
        check({oc, od}, {~exp_a, exp_a}, "C D copies");
        drive_in(1'h0);
        step(8);
        check(phase, exp_a, "phase after pulse");
    endtask
    task automatic test_push_pull;
        setup(CWBD_PUSH_PULL, 4'h3, 4'h0, CLK_SEL_SYS);
        start;
        pp_pulse(1'h1);
        pp_pulse(1'h0);
        pp_pulse(1'h1);
        @(posedge clk);
        sd <= 1'h1;
        @(posedge clk);
        sd <= 1'h0;
        step(2);
        pp_pulse(1'h1);
        @(posedge clk);
        en <= 1'h0;
        step(2);
        start;
        pp_pulse(1'h1);
        $display("test push pull done");
    endtask
    task automatic test_full;
        setup(CWBD_FULL_FWD, 4'hF, 4'h0, CLK_SEL_SYS);
        write_db(6'h02, 6'h01, 1'h0);
        start;
        check(outs, 4'h1, "fwd static");
        drive_in(1'h1);
        step(6);
        check(outs, 4'h9, "fwd modulated");
        drive_in(1'h0);
        step(4);
        @(posedge clk);
        cfg.mode <= CWBD_FULL_REV;
        step(5);
        check(outs, 4'h1, "no change before edge");
        drive_in(1'h1);
        edges_until(2, 1'h1, n);
        check(n, 4, "static switch");
        check({oa, ob, od}, 3'h0, "rev static");
        edges_until(1, 1'h1, m);
        check(n + m, 7, "rev dead band");
        check(dir, 1'h1, "direction");
        drive_in(1'h0);
        step(5);
        check(outs, 4'h4, "rev modulated");
        $display("test full done");
    endtask
    task automatic test_steer;
        setup(CWBD_STEER_ASYNC, 4'h3, 4'h5, CLK_SEL_SYS);
        start;
        drive_in(1'h1);
        step(5);
        check(outs, 4'h1, "steer A C");
        @(posedge clk);
        cfg.steer <= 4'hA;
        step(3);
        check(outs, 4'h2, "async update");
        @(posedge clk);
        src[0] <= 1'h1;
        step(5);
        check(outs, 4'h2, "other source ignored");
        @(posedge clk);
        cfg <= '{CWBD_STEER_SYNC, 4'h3, 4'h5, CLK_SEL_SYS, 4'h5};
        step(5);
        check(outs, 4'h2, "sync holds");
        drive_in(1'h0);
        step(5);
        check(outs, 4'h8, "sync holds low");
        drive_in(1'h1);
        step(5);
        check(outs, 4'h1, "sync applies");
        $display("test steer done");
    endtask
    task automatic test_fast_clock;
        setup(CWBD_HALF, 4'hF, 4'h0, CLK_SEL_FAST);
        write_db(6'h08, 6'h00, 1'h0);
        start;
        drive_in(1'h1);
        edges_until(0, 1'h1, n);
        check(n >= 20 && n <= 25, 1'h1, "slow dead band");
        $display("test fast clock done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish;
    end
    initial
    begin
        rst_n = 1'h0;
        en = 1'h0;
        sd = 1'h0;
        src = 16'h0000;
        dbw = '0;
        cfg = '{CWBD_HALF, 4'hF, 4'h0, CLK_SEL_SYS, 4'h5};
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        step(2);
        test_half;
        test_short_and_load;
        test_push_pull;
        test_full;
        test_steer;
        test_fast_clock;
        tally_and_finish;
    end
endmodule
